// ### spl_cfg.svh
// constants for the sector protection logic: sizes, bit positions, offsets, timing
`ifndef SPL_CFG_SVH
`define SPL_CFG_SVH

`define SPL_NSECT 32
`define SPL_SECT_W 5
`define SPL_BANK_W 4
`define SPL_BANK0 4'h0
`define SPL_LOCK_W 16
`define SPL_LK_SEC 0
`define SPL_LK_PERS 1
`define SPL_LK_PASS 2
`define SPL_LK_ERS 3
`define SPL_LK_FORCE 16'hFFF0
`define SPL_LK_RST 16'hFFFF
`define SPL_VOL_RST {`SPL_NSECT{1'b1}}
`define SPL_ADDR_W 8
`define SPL_DATA_W 16
`define SPL_A_LOCK 8'h00
`define SPL_A_STATUS 8'h04
`define SPL_A_SEL 8'h08
`define SPL_A_SECT 8'h0C
`define SPL_A_CTRL 8'h10
`define SPL_CTRL_GLOCK 0
`define SPL_CTRL_CLRFAIL 1
`define SPL_CLK_NS 50
`define SPL_PROG_NS 2000
`define SPL_ERS_NS 5000
`define SPL_TMO_NS 1000
`define SPL_PROG_CYC ((`SPL_PROG_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_ERS_CYC ((`SPL_ERS_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_TMO_CYC ((`SPL_TMO_NS + `SPL_CLK_NS - 1) / `SPL_CLK_NS)
`define SPL_CNT_W 8
`define SPL_CNT_ZERO 8'h00
`define SPL_CNT_ONE 8'h01

`endif

// ### spl_chk_checker.sv
// assertion checker for the sector protection logic
`timescale 1ns/1ps
`include "spl_cfg.svh"
module spl_chk
  import spl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // power-up load
  input wire logic nv_load,
  input wire logic [`SPL_NSECT-1:0] nv_pers_init,
  input wire logic [`SPL_LOCK_W-1:0] nv_lock_init,
  // commands
  input wire spl_cmd_s cmd,
  input wire logic op_suspended,
  input wire logic pw_match,
  input wire logic cmd_grant,
  input wire logic cmd_ignored,
  // array cycles
  input wire spl_acc_s acc,
  input wire logic wr_allow,
  input wire spl_rd_s rd_resp,
  // register port
  input wire logic [`SPL_ADDR_W-1:0] reg_addr,
  input wire logic [`SPL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`SPL_DATA_W-1:0] reg_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic lr_reg;
  logic pb_reg;
  logic [3:0] bank_reg;
  wire idle = !lr_reg && !pb_reg;
  wire entry = idle && (cmd.op == LR_ENTRY || cmd.op == PB_ENTRY);
  // mirrors mode entry and exit; exits during busy are never issued by the bench
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      lr_reg <= 1'b0;
      pb_reg <= 1'b0;
      bank_reg <= 4'h0;
    end else if (cmd.op == MODE_EXIT) begin
      lr_reg <= 1'b0;
      pb_reg <= 1'b0;
    end else if (entry && !op_suspended) begin
      lr_reg <= cmd.op == LR_ENTRY;
      pb_reg <= cmd.op == PB_ENTRY;
      bank_reg <= cmd.sector[4:1];
    end
  end
  a_entry_susp_ign: assert property (entry && op_suspended |=> cmd_ignored)
    else $error("entry while suspended not refused");
  a_grant_cause: assert property (cmd_grant |-> $past(cmd.op) inside {ARR_PROG, ARR_ERASE})
    else $error("grant without array command");
  a_ignore_cause: assert property (cmd_ignored |-> $past(cmd.op) != OP_NONE)
    else $error("refusal without command");
  a_lock_high_ones: assert property (reg_rd && reg_addr == `SPL_A_LOCK |=> reg_rdata[15:4] == 12'hFFF)
    else $error("lock word upper bits not ones");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_lr_bank0_block: assert property (lr_reg && acc.rd && acc.sector[4:1] == 4'h0 |=> !rd_resp.ok || rd_resp.status_src)
    else $error("bank 0 array data in lock mode");
  a_mode_wr_block: assert property (!idle && acc.wr |-> !wr_allow)
    else $error("write allowed inside a mode");
  a_idle_wr_open: assert property (idle && acc.wr |-> wr_allow)
    else $error("write refused in read mode");
  a_pb_bank_src: assert property (pb_reg && acc.rd && acc.sector[4:1] == bank_reg |=> rd_resp.pers_src || rd_resp.status_src)
    else $error("selected bank read not protection status");
  a_resp_cause: assert property (rd_resp.ok || rd_resp.pers_src |-> $past(acc.rd))
    else $error("read answer without read");
  c_grant: cover property (cmd_grant);
  c_ignored: cover property (cmd_ignored);
  c_pers_read: cover property (pb_reg && rd_resp.pers_src);
endmodule // spl_chk

bind spl_sector_protection spl_chk u_chk (.mclk(mclk), .arst_n(arst_n), .nv_load(nv_load),
  .nv_pers_init(nv_pers_init), .nv_lock_init(nv_lock_init), .cmd(cmd),
  .op_suspended(op_suspended), .pw_match(pw_match), .cmd_grant(cmd_grant),
  .cmd_ignored(cmd_ignored), .acc(acc), .wr_allow(wr_allow), .rd_resp(rd_resp),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));

// ### spl_host.sv
// host memory controller model: command and array cycles
`timescale 1ns/1ps
module spl_host
  import spl_pkg::*;
(
  // clock
  input wire logic mclk,
  // command side
  output spl_cmd_s cmd,
  output logic op_suspended,
  output logic pw_match,
  // array side
  output spl_acc_s acc,
  input wire logic wr_allow,
  input wire spl_rd_s rd_resp
);
  initial begin
    cmd = '{OP_NONE, 5'h00, 1'b0, 16'h0000};
    acc = '{1'b0, 1'b0, 5'h00};
    op_suspended = 1'b0;
    pw_match = 1'b0;
  end
  // sector bits travel in the command's own cycle
  task automatic issue(input spl_op_e op, input logic [4:0] s, input logic sc,
      input logic [15:0] d);
    @(posedge mclk);
    cmd <= '{op, s, sc, d};
    @(posedge mclk);
    // released fields flip so a stale value cannot pass for a fresh one
    cmd <= '{OP_NONE, ~s, ~sc, ~d};
    #1;
  endtask
  // one-cycle read answered from a register on the next edge; never aimed elsewhere during lock programming
  task automatic rd(input logic [4:0] s, output spl_rd_s r);
    @(posedge mclk);
    acc <= '{1'b1, 1'b0, s};
    @(posedge mclk);
    acc <= '{1'b0, 1'b0, ~s};
    #1;
    r = rd_resp;
  endtask
  task automatic wr(input logic [4:0] s, output logic a);
    @(posedge mclk);
    acc <= '{1'b0, 1'b1, s};
    #1;
    a = wr_allow;
    @(posedge mclk);
    acc <= '{1'b0, 1'b0, ~s};
  endtask
  // match raised only after the password was programmed and verified
  task automatic flags(input logic su, input logic pm);
    @(posedge mclk);
    op_suspended <= su;
    pw_match <= pm;
  endtask
endmodule // spl_host

// ### spl_pkg.sv
// types shared by the sector protection logic
package spl_pkg;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    ARR_PROG  = 4'h1,
    ARR_ERASE = 4'h2,
    LR_ENTRY  = 4'h3,
    LR_PROG   = 4'h4,
    PB_ENTRY  = 4'h5,
    PB_PROG   = 4'h6,
    PB_ERASE  = 4'h7,
    VOL_SET   = 4'h8,
    VOL_CLR   = 4'h9,
    GLOCK_SET = 4'hA,
    PW_UNLOCK = 4'hB,
    MODE_EXIT = 4'hC
  } spl_op_e;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_PB_MODE  = 3'b001,
    ST_PB_BUSY  = 3'b011,
    ST_PB_PREP  = 3'b010,
    ST_PB_ERASE = 3'b110,
    ST_LR_MODE  = 3'b100,
    ST_LR_BUSY  = 3'b101
  } spl_state_e;

  typedef struct packed {
    spl_op_e op;
    logic [4:0] sector;
    logic secure;
    logic [15:0] data;
  } spl_cmd_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] sector;
  } spl_acc_s;

  typedef struct packed {
    logic ok;
    logic status_src;
    logic pers_src;
    logic pers_bit;
  } spl_rd_s;

  typedef struct packed {
    logic [6:0] pad;
    spl_state_e state;
    logic busy;
    logic fail;
    logic glock;
    logic pass_mode;
    logic pers_mode;
    logic lr_abort;
  } spl_status_s;

endpackage

// ### spl_sector_protection.sv
// sector protection logic: per-sector bits, lock register, bank gating
`timescale 1ns/1ps
`include "spl_cfg.svh"

module spl_sector_protection
  import spl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // nonvolatile contents loaded at power-up
  input wire logic nv_load,
  input wire logic [`SPL_NSECT-1:0] nv_pers_init,
  input wire logic [`SPL_LOCK_W-1:0] nv_lock_init,
  // command sequences from the host
  input wire spl_cmd_s cmd,
  input wire logic op_suspended,
  input wire logic pw_match,
  output logic cmd_grant,
  output logic cmd_ignored,
  // array read and write cycles
  input wire spl_acc_s acc,
  output logic wr_allow,
  output spl_rd_s rd_resp,
  // register port
  input wire logic [`SPL_ADDR_W-1:0] reg_addr,
  input wire logic [`SPL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`SPL_DATA_W-1:0] reg_rdata
);

  spl_state_e state_reg;
  spl_state_e state_next;
  logic [`SPL_NSECT-1:0] pers_reg;
  logic [`SPL_NSECT-1:0] vol_reg;
  logic [`SPL_LOCK_W-1:0] lock_reg;
  logic glock_reg;
  logic boot_reg;
  logic fail_reg;
  logic abort_reg;
  logic [`SPL_CNT_W-1:0] cnt_reg;
  logic [`SPL_CNT_W-1:0] cnt_next;
  logic [`SPL_BANK_W-1:0] sel_bank_reg;
  logic [`SPL_SECT_W-1:0] tgt_reg;
  logic tmo_reg;
  logic [`SPL_SECT_W-1:0] reg_sel_reg;
  logic grant_next;
  logic ignored_next;
  logic entry_ok;
  logic pers_mode;
  logic pass_mode;
  logic lr_both;
  logic lr_conflict;
  logic cnt_done;
  logic [`SPL_BANK_W-1:0] acc_bank;
  spl_rd_s rd_next;
  spl_status_s status;

  // bank that holds a sector: two sectors per bank
  function automatic logic [`SPL_BANK_W-1:0] bank_of(input logic [`SPL_SECT_W-1:0] s);
    bank_of = s[`SPL_SECT_W-1:1];
  endfunction

  function automatic logic sect_protected(input logic [`SPL_SECT_W-1:0] s);
    sect_protected = !pers_reg[s] || !vol_reg[s];
  endfunction

  assign pers_mode = !lock_reg[`SPL_LK_PERS] && lock_reg[`SPL_LK_PASS];
  assign pass_mode = lock_reg[`SPL_LK_PERS] && !lock_reg[`SPL_LK_PASS];
  assign entry_ok = !op_suspended;
  assign cnt_done = (cnt_reg == `SPL_CNT_ONE);
  assign acc_bank = bank_of(acc.sector);

  // programming clears bits only; both mode bits at once is refused outright
  assign lr_both = !cmd.data[`SPL_LK_PERS] && !cmd.data[`SPL_LK_PASS];
  // once one mode bit is programmed the other can never be
  assign lr_conflict = (!cmd.data[`SPL_LK_PERS] && !lock_reg[`SPL_LK_PASS])
                    || (!cmd.data[`SPL_LK_PASS] && !lock_reg[`SPL_LK_PERS]);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    grant_next = 1'b0;
    ignored_next = 1'b0;
    if (cnt_reg != `SPL_CNT_ZERO) begin
      cnt_next = cnt_reg - `SPL_CNT_ONE;
    end
    case (state_reg)
      ST_IDLE: begin
        case (cmd.op)
          ARR_PROG, ARR_ERASE: begin
            // decision taken at acceptance, before any cell changes
            if (cmd.secure ? !lock_reg[`SPL_LK_SEC] : sect_protected(cmd.sector)) begin
              ignored_next = 1'b1;
            end else begin
              grant_next = 1'b1;
            end
          end
          LR_ENTRY: begin
            if (entry_ok) begin
              state_next = ST_LR_MODE;
            end else begin
              ignored_next = 1'b1;
            end
          end
          PB_ENTRY: begin
            if (entry_ok) begin
              state_next = ST_PB_MODE;
            end else begin
              ignored_next = 1'b1;
            end
          end
          OP_NONE, VOL_SET, VOL_CLR, GLOCK_SET, PW_UNLOCK, MODE_EXIT: begin
          end
          default: begin
            ignored_next = 1'b1;
          end
        endcase
      end
      ST_LR_MODE: begin
        if (cmd.op == LR_PROG) begin
          // an aborted program never goes busy, so the host can exit at once
          if (!lr_both && !lr_conflict) begin
            state_next = ST_LR_BUSY;
            cnt_next = `SPL_CNT_W'(`SPL_PROG_CYC);
          end
        end else if (cmd.op == MODE_EXIT) begin
          state_next = ST_IDLE;
        end
      end
      ST_LR_BUSY: begin
        if (cnt_done) begin
          state_next = ST_LR_MODE;
        end
      end
      ST_PB_MODE: begin
        if (cmd.op == PB_PROG) begin
          state_next = ST_PB_BUSY;
          cnt_next = glock_reg ? `SPL_CNT_W'(`SPL_TMO_CYC) : `SPL_CNT_W'(`SPL_PROG_CYC);
        end else if (cmd.op == PB_ERASE) begin
          if (!lock_reg[`SPL_LK_ERS]) begin
            ignored_next = 1'b1;
          end else if (glock_reg) begin
            state_next = ST_PB_BUSY;
            cnt_next = `SPL_CNT_W'(`SPL_TMO_CYC);
          end else begin
            state_next = ST_PB_PREP;
            cnt_next = `SPL_CNT_W'(`SPL_PROG_CYC);
          end
        end else if (cmd.op == MODE_EXIT) begin
          state_next = ST_IDLE;
        end
      end
      ST_PB_BUSY: begin
        if (cnt_done) begin
          state_next = ST_PB_MODE;
        end
      end
      ST_PB_PREP: begin
        if (cnt_done) begin
          state_next = ST_PB_ERASE;
          cnt_next = `SPL_CNT_W'(`SPL_ERS_CYC);
        end
      end
      ST_PB_ERASE: begin
        if (cnt_done) begin
          state_next = ST_PB_MODE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= `SPL_CNT_ZERO;
      cmd_grant <= 1'b0;
      cmd_ignored <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cmd_grant <= grant_next;
      cmd_ignored <= ignored_next;
    end
  end

  // bank chosen at persistent-mode entry, and target of a pending program
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_bank_reg <= `SPL_BANK0;
      tgt_reg <= '0;
      tmo_reg <= 1'b0;
    end else begin
      if (state_reg == ST_IDLE && cmd.op == PB_ENTRY) begin
        sel_bank_reg <= bank_of(cmd.sector);
      end
      if (state_reg == ST_PB_MODE && (cmd.op == PB_PROG || cmd.op == PB_ERASE)) begin
        tgt_reg <= cmd.sector;
        tmo_reg <= glock_reg;
      end
    end
  end

  // nonvolatile storage keeps its contents through hardware reset
  always_ff @(posedge mclk) begin
    if (nv_load) begin
      pers_reg <= nv_pers_init;
    end else if (state_reg == ST_PB_BUSY && cnt_done && !tmo_reg) begin
      pers_reg[tgt_reg] <= 1'b0;
    end else if (state_reg == ST_PB_ERASE && cnt_done) begin
      pers_reg <= `SPL_VOL_RST;
    end
  end

  always_ff @(posedge mclk) begin
    if (nv_load) begin
      lock_reg <= nv_lock_init;
    end else if (state_reg == ST_LR_MODE && cmd.op == LR_PROG && !lr_both && !lr_conflict) begin
      lock_reg <= lock_reg & cmd.data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      vol_reg <= `SPL_VOL_RST;
    end else if (state_reg == ST_IDLE && cmd.op == VOL_SET) begin
      vol_reg[cmd.sector] <= 1'b0;
    end else if (state_reg == ST_IDLE && cmd.op == VOL_CLR) begin
      vol_reg[cmd.sector] <= 1'b1;
    end
  end

  // reset forces a constant; the password-mode set happens on the first edge after release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      glock_reg <= 1'b0;
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        glock_reg <= pass_mode;
      end else if (cmd.op == GLOCK_SET
                   || (reg_wr && reg_addr == `SPL_A_CTRL && reg_wdata[`SPL_CTRL_GLOCK])) begin
        glock_reg <= 1'b1;
      end else if (cmd.op == PW_UNLOCK && pass_mode && pw_match) begin
        glock_reg <= 1'b0;
      end
    end
  end

  // fail is sticky: a new failure in the clear cycle wins
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fail_reg <= 1'b0;
      abort_reg <= 1'b0;
    end else begin
      if (ignored_next || (state_reg == ST_PB_BUSY && cnt_done && tmo_reg)) begin
        fail_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `SPL_A_CTRL && reg_wdata[`SPL_CTRL_CLRFAIL]) begin
        fail_reg <= 1'b0;
      end
      if (state_reg == ST_LR_MODE && cmd.op == LR_PROG && (lr_both || lr_conflict)) begin
        abort_reg <= 1'b1;
      end else if (reg_wr && reg_addr == `SPL_A_CTRL && reg_wdata[`SPL_CTRL_CLRFAIL]) begin
        abort_reg <= 1'b0;
      end
    end
  end

  // bank gating for array cycles
  always_comb begin
    rd_next = '0;
    wr_allow = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        rd_next.ok = acc.rd;
        wr_allow = acc.wr;
      end
      ST_LR_MODE: begin
        rd_next.ok = acc.rd && (acc_bank != `SPL_BANK0);
      end
      ST_LR_BUSY: begin
        // only status polling at bank 0 while the lock word programs
        rd_next.ok = acc.rd && (acc_bank == `SPL_BANK0);
        rd_next.status_src = rd_next.ok;
      end
      ST_PB_MODE: begin
        rd_next.ok = acc.rd;
        rd_next.pers_src = acc.rd && (acc_bank == sel_bank_reg);
        rd_next.pers_bit = pers_reg[acc.sector];
      end
      ST_PB_BUSY: begin
        // no array data anywhere while a persistent bit programs
        rd_next.ok = acc.rd && (acc_bank == sel_bank_reg);
        rd_next.status_src = rd_next.ok;
      end
      ST_PB_PREP, ST_PB_ERASE: begin
        rd_next.ok = acc.rd;
        rd_next.status_src = acc.rd && (acc_bank == sel_bank_reg);
      end
      default: begin
        rd_next = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_resp <= '0;
    end else begin
      rd_resp <= rd_next;
    end
  end

  // register port
  assign status = '{pad: '0, state: state_reg, busy: (cnt_reg != `SPL_CNT_ZERO),
                    fail: fail_reg, glock: glock_reg, pass_mode: pass_mode,
                    pers_mode: pers_mode, lr_abort: abort_reg};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_sel_reg <= '0;
    end else if (reg_wr && reg_addr == `SPL_A_SEL) begin
      reg_sel_reg <= reg_wdata[`SPL_SECT_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        `SPL_A_LOCK: reg_rdata <= lock_reg | `SPL_LK_FORCE;
        `SPL_A_STATUS: reg_rdata <= status;
        `SPL_A_SEL: reg_rdata <= {{(`SPL_DATA_W-`SPL_SECT_W){1'b0}}, reg_sel_reg};
        `SPL_A_SECT: reg_rdata <= {13'h0000, sect_protected(reg_sel_reg),
                                   vol_reg[reg_sel_reg], pers_reg[reg_sel_reg]};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule // spl_sector_protection

// ### tb.sv
// self-checking testbench for the sector protection logic
`timescale 1ns/1ps
`include "spl_cfg.svh"
module tb
  import spl_pkg::*;
;
  logic mclk, arst_n, nv_load, reg_wr, reg_rd, op_suspended, pw_match;
  logic cmd_grant, cmd_ignored, wr_allow, a;
  logic [`SPL_NSECT-1:0] nv_pers_init;
  logic [`SPL_LOCK_W-1:0] nv_lock_init;
  logic [`SPL_ADDR_W-1:0] reg_addr;
  logic [`SPL_DATA_W-1:0] reg_wdata, reg_rdata, d;
  spl_cmd_s cmd;
  spl_acc_s acc;
  spl_rd_s rd_resp, r;
  int failures = 0;
  int samples_checked = 0;
  int n;
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  spl_sector_protection DUT (.mclk(mclk), .arst_n(arst_n), .nv_load(nv_load),
    .nv_pers_init(nv_pers_init), .nv_lock_init(nv_lock_init), .cmd(cmd),
    .op_suspended(op_suspended), .pw_match(pw_match), .cmd_grant(cmd_grant),
    .cmd_ignored(cmd_ignored), .acc(acc), .wr_allow(wr_allow), .rd_resp(rd_resp),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  spl_host host (.mclk(mclk), .cmd(cmd), .op_suspended(op_suspended),
    .pw_match(pw_match), .acc(acc), .wr_allow(wr_allow), .rd_resp(rd_resp));
  task automatic results();
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h got %h", nm, e, g);
      failures++;
    end
  endtask
  task automatic rw(input logic [7:0] ad, input logic [15:0] wd);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= wd;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rr(input logic [7:0] ad, output logic [15:0] q);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    q = reg_rdata;
  endtask
  task automatic cc(input string nm, input spl_op_e op, input logic [4:0] s,
      input logic sc, input logic [1:0] e);
    host.issue(op, s, sc, 16'h0000);
    chk(nm, 16'(e), 16'({cmd_grant, cmd_ignored}));
  endtask
  // polls busy; each poll spans two cycles
  task automatic wait_idle(output int k);
    k = 0;
    do begin
      rr(`SPL_A_STATUS, d);
      k++;
    end while (d[5] !== 1'b0 && k < 200);
    if (k >= 200) begin
      failures++;
      results();
    end
  endtask
  // nonvolatile words load inside reset so the first edge after release sees them
  task automatic power_up(input logic [15:0] lk);
    @(posedge mclk);
    arst_n <= 1'b0;
    nv_load <= 1'b1;
    nv_lock_init <= lk;
    repeat (4) @(posedge mclk);
    nv_load <= 1'b0;
    arst_n <= 1'b1;
    @(posedge mclk);
  endtask
  initial begin
    arst_n = 1'b0;
    nv_load = 1'b0;
    nv_pers_init = 32'hFFFFFFFE;
    nv_lock_init = 16'h0006;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    power_up(16'h0006);
    rr(`SPL_A_LOCK, d);
    chk("lock", 16'hFFF6, d);
    rr(8'hFC, d);
    chk("unmapped", 16'h0000, d);
    rw(`SPL_A_SEL, 16'h0003);
    rr(`SPL_A_SECT, d);
    chk("sect3", 16'h0003, d);
    cc("prot_pers", ARR_PROG, 5'd0, 1'b0, 2'b01);
    cc("open", ARR_ERASE, 5'd3, 1'b0, 2'b10);
    host.issue(VOL_SET, 5'd3, 1'b0, 16'h0000);
    cc("prot_vol", ARR_PROG, 5'd3, 1'b0, 2'b01);
    host.issue(VOL_CLR, 5'd3, 1'b0, 16'h0000);
    cc("secure", ARR_PROG, 5'd3, 1'b1, 2'b01);
    host.flags(1'b1, 1'b0);
    cc("susp_lr", LR_ENTRY, 5'd0, 1'b0, 2'b01);
    cc("susp_pb", PB_ENTRY, 5'd6, 1'b0, 2'b01);
    host.flags(1'b0, 1'b0);
    host.issue(LR_ENTRY, 5'd0, 1'b0, 16'h0000);
    host.rd(5'd0, r);
    chk("lr_b0", 16'h0000, 16'(r.ok));
    host.rd(5'd4, r);
    chk("lr_b2", 16'h0001, 16'(r.ok));
    host.wr(5'd4, a);
    chk("lr_wr", 16'h0000, 16'(a));
    host.issue(LR_PROG, 5'd0, 1'b0, 16'hFFF9);
    rr(`SPL_A_STATUS, d);
    chk("both_abort", 16'h0001, 16'(d[0]));
    rw(`SPL_A_CTRL, 16'h0002);
    host.issue(LR_PROG, 5'd0, 1'b0, 16'hFFFD);
    host.rd(5'd0, r);
    chk("poll", 16'h0003, 16'({r.ok, r.status_src}));
    wait_idle(n);
    rr(`SPL_A_LOCK, d);
    chk("pers_lock", 16'hFFF4, d);
    host.issue(LR_PROG, 5'd0, 1'b0, 16'hFFFB);
    rr(`SPL_A_LOCK, d);
    chk("no_switch", 16'hFFF4, d);
    host.issue(MODE_EXIT, 5'd0, 1'b0, 16'h0000);
    rw(`SPL_A_CTRL, 16'h0002);
    rr(`SPL_A_STATUS, d);
    chk("mode", 16'h0002, 16'(d[5:0]));
    host.issue(PB_ENTRY, 5'd6, 1'b0, 16'h0000);
    host.rd(5'd6, r);
    chk("pb_src", 16'h0003, 16'({r.pers_src, r.pers_bit}));
    host.issue(PB_PROG, 5'd6, 1'b0, 16'h0000);
    host.rd(5'd10, r);
    chk("pb_other", 16'h0000, 16'(r.ok));
    wait_idle(n);
    chk("prog_time", 16'h0001, 16'(n >= 19 && n <= 22));
    host.rd(5'd6, r);
    chk("pb_bit", 16'h0002, 16'({r.pers_src, r.pers_bit}));
    host.rd(5'd7, r);
    chk("pb_one", 16'h0003, 16'({r.pers_src, r.pers_bit}));
    cc("ers_off", PB_ERASE, 5'd6, 1'b0, 2'b01);
    host.issue(MODE_EXIT, 5'd6, 1'b0, 16'h0000);
    host.wr(5'd0, a);
    chk("exit_wr", 16'h0001, 16'(a));
    cc("prot6", ARR_PROG, 5'd6, 1'b0, 2'b01);
    rw(`SPL_A_CTRL, 16'h0003);
    host.issue(PB_ENTRY, 5'd8, 1'b0, 16'h0000);
    host.issue(PB_PROG, 5'd8, 1'b0, 16'h0000);
    wait_idle(n);
    chk("tmo_time", 16'h0001, 16'(n >= 9 && n <= 12));
    chk("tmo_fail", 16'h0001, 16'(d[4]));
    host.rd(5'd8, r);
    chk("tmo_keep", 16'h0003, 16'({r.pers_src, r.pers_bit}));
    host.issue(MODE_EXIT, 5'd8, 1'b0, 16'h0000);
    rw(`SPL_A_CTRL, 16'h0002);
    rr(`SPL_A_STATUS, d);
    chk("glock_kept", 16'h0001, 16'(d[3]));
    power_up(16'h000B);
    power_up(16'h000B);
    rr(`SPL_A_STATUS, d);
    chk("pw_glock", 16'h000C, 16'(d[3:0]));
    host.issue(PW_UNLOCK, 5'd0, 1'b0, 16'h0000);
    rr(`SPL_A_STATUS, d);
    chk("pw_bad", 16'h0001, 16'(d[3]));
    host.flags(1'b0, 1'b1);
    host.issue(PW_UNLOCK, 5'd0, 1'b0, 16'h0000);
    host.flags(1'b0, 1'b0);
    rr(`SPL_A_STATUS, d);
    chk("pw_good", 16'h0000, 16'(d[3]));
    host.issue(PB_ENTRY, 5'd0, 1'b0, 16'h0000);
    host.issue(PB_ERASE, 5'd0, 1'b0, 16'h0000);
    wait_idle(n);
    chk("ers_time", 16'h0001, 16'(n >= 68 && n <= 73));
    host.rd(5'd0, r);
    chk("ers_all", 16'h0003, 16'({r.pers_src, r.pers_bit}));
    host.issue(MODE_EXIT, 5'd0, 1'b0, 16'h0000);
    results();
  end
endmodule // tb
